/* verilog/tbcr_pkg.sv */
/*
  Constants for the triple buck control register bank: register offsets,
  field positions, reset values, slew and address constants.
  Assumes a single 50 MHz core clock and a synchronous active-high reset.
*/
// Functional notes
// - Voltage code applied only while apply bit set
// - Seven-bit code, 10 mV steps from base
// - Channel 1 bit 0 active-low enable, resets zero
// - Channel 2 bit 0 active-low enable, resets zero
// - Channel 3 bit 0 active-low enable, resets zero
// - Channel 1 bit 1 forces continuous switching
// - Channel 2 bit 1 forces continuous, resets zero
// - Channel 3 bit 1 forces continuous, resets zero
// - Output 2 steps once per 2^N switching cycles
// - Status bit 7 shows thermal shutdown
// - Status bit 3 shows thermal warning
// - Status bits 6..4 show overcurrent per channel
// - Status bits 2..0 show power good per channel
// - Status read-only; control registers fully read/write
// - Decode 0x01, 0x03 to 0x05, 0x06
// - Write is address, register, data; commit after data
// - Seven-bit addressing only; ignore general call, 10-bit
// - Refuse writes while all enable pins low
package tbcr_pkg;
  localparam logic [7:0] TBCR_ADDR_VSEL = 8'h01;
  localparam logic [7:0] TBCR_ADDR_CH1 = 8'h03;
  localparam logic [7:0] TBCR_ADDR_CH2 = 8'h04;
  localparam logic [7:0] TBCR_ADDR_CH3 = 8'h05;
  localparam logic [7:0] TBCR_ADDR_STAT = 8'h06;
  localparam logic [7:0] TBCR_RST_VSEL = 8'h00;
  localparam logic [7:0] TBCR_RST_CMD = 8'h00;
  localparam logic [7:0] TBCR_RST_STAT = 8'h00;
  localparam int TBCR_APPLY_BIT = 7;
  localparam int TBCR_DISABLE_BIT = 0;
  localparam int TBCR_FCC_BIT = 1;
  localparam int TBCR_SLEW_LSB = 4;
  localparam int TBCR_SLEW_MSB = 6;
  localparam int TBCR_STAT_OTP = 7;
  localparam int TBCR_STAT_OC_LSB = 4;
  localparam int TBCR_STAT_OTW = 3;
  localparam int TBCR_STAT_PG_LSB = 0;
  localparam logic [6:0] TBCR_CODE_MIN = 7'h00;
  localparam logic [6:0] TBCR_CODE_MAX = 7'h7F;
  localparam logic [6:0] TBCR_GEN_CALL = 7'h00;
  localparam logic [6:0] TBCR_TENBIT_PFX = 7'h78;
  localparam logic [6:0] TBCR_TENBIT_MSK = 7'h7C;
  localparam logic [6:0] TBCR_DEV_ADDR_DEF = 7'h5E;
  typedef enum logic [1:0] {
    TBCR_IDLE = 2'b00,
    TBCR_REG = 2'b01,
    TBCR_DATA = 2'b10,
    TBCR_SKIP = 2'b11
  } tbcr_state_t;
endpackage

/* verilog/tbcr_slew.sv */
/*
  Output 2 voltage code slewer: walks the live code toward the target one
  step each 2^N switching cycles.
  Assumes sw_tick is a one-cycle pulse per switching cycle in core_clk.
*/
`timescale 1ns/10ps
module tbcr_slew
  import tbcr_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic sw_tick, // Switching cycle pulse
  input wire logic apply, // Apply target code
  input wire logic [6:0] target, // Target code
  input wire logic [2:0] slew_n, // Step interval exponent
  output logic [6:0] code_out, // Live code
  output logic step_pulse // One step taken
);
  logic [6:0] code_r;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] code_nxt;
  wire [6:0] span = 7'((8'h01 << slew_n) - 8'h01);
  wire moving = apply && (code_r != target);
  wire due = sw_tick && moving && (cnt_r >= span);
  assign code_nxt = !due ? code_r : (code_r < target) ? code_r + 7'h01 : code_r - 7'h01;
  assign cnt_nxt = !moving ? 7'h00 : due ? 7'h00 : sw_tick ? cnt_r + 7'h01 : cnt_r;
  assign code_out = code_r;
  assign step_pulse = due;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      code_r <= TBCR_CODE_MIN;
      cnt_r <= 7'h00;
    end else begin
      code_r <= code_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  step_one_a: assert property (@(posedge core_clk) disable iff (rst)
      step_pulse |=> (code_r == $past(code_r) + 7'h01) || (code_r == $past(code_r) - 7'h01))
    else $error("slew step not one code");
  hold_off_a: assert property (@(posedge core_clk) disable iff (rst)
      !apply |=> $stable(code_r))
    else $error("code moved without apply");
  fast_cov: cover property (@(posedge core_clk) disable iff (rst)
      step_pulse && slew_n == 3'h0);
endmodule

/* verilog/tbcr_regs.sv */
/*
  Register bank of the triple step-down converter control port. A byte
  engine delivers start, stop and received bytes; this block decodes the
  address, register and data bytes, holds the control registers and
  returns read data and acknowledge.
  Assumes the bit engine gives one-cycle pulses in core_clk; monitor
  inputs and enable pins come from other domains and are synchronised.
*/
`timescale 1ns/10ps
module tbcr_regs
  import tbcr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = TBCR_DEV_ADDR_DEF // Arbitrary value
)(
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst, // Sync reset, active high
  input wire logic bus_start, // Start or repeated start pulse
  input wire logic bus_stop, // Stop pulse
  input wire logic byte_valid, // Received byte pulse
  input wire logic [7:0] byte_data, // Received byte
  input wire logic rd_req, // Read data byte request pulse
  output logic byte_ack, // Acknowledge for current byte
  output logic [7:0] rd_data, // Read data byte
  input wire logic [2:0] en_pin, // Hardware enable pins, async
  input wire logic over_temp_in, // Thermal shutdown, async
  input wire logic temp_warn_in, // Thermal warning, async
  input wire logic [2:0] overcurrent_in, // Hiccup per channel, async
  input wire logic [2:0] in_regulation_in, // Power good per channel, async
  input wire logic sw_tick, // Switching cycle pulse
  output logic [6:0] voltage_code, // Live output 2 code
  output logic voltage_code_apply, // Code controls output 2
  output logic channel1_disable, // Channel 1 off
  output logic channel2_disable, // Channel 2 off
  output logic channel3_disable, // Channel 3 off
  output logic channel1_forced_continuous, // Channel 1 forced PWM
  output logic channel2_forced_continuous, // Channel 2 forced PWM
  output logic channel3_forced_continuous // Channel 3 forced PWM
);
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == TBCR_ADDR_VSEL) || (a == TBCR_ADDR_CH1) ||
                (a == TBCR_ADDR_CH2) || (a == TBCR_ADDR_CH3) || (a == TBCR_ADDR_STAT);
  endfunction

  tbcr_state_t state_r, state_nxt;
  logic [7:0] vsel_r, ch1_r, ch2_r, ch3_r;
  logic [7:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt;
  logic [7:0] rd_r;
  logic [7:0] stat_live;
  // Three-stage synchronisers; second and third must agree before a change counts
  // Packing: [10:8] enable pins, [7] shutdown, [6] warning, [5:3] overcurrent, [2:0] power good
  logic [10:0] s1_r, s2_r, s3_r, mon_r;
  wire [10:0] mon_async = {en_pin, over_temp_in, temp_warn_in, overcurrent_in,
                           in_regulation_in};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_r <= 11'h000;
      s2_r <= 11'h000;
      s3_r <= 11'h000;
      mon_r <= 11'h000;
    end else begin
      s1_r <= mon_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      mon_r <= (s2_r & s3_r) | (mon_r & (s2_r | s3_r));
    end
  end
  wire [2:0] en_sync = mon_r[10:8];
  wire hw_shutdown = (en_sync == 3'b000);
  assign stat_live = {mon_r[7], mon_r[5:3], mon_r[6], mon_r[2:0]};

  wire [6:0] addr7 = byte_data[7:1];
  wire addr_bad = (addr7 == TBCR_GEN_CALL) ||
                  ((addr7 & TBCR_TENBIT_MSK) == TBCR_TENBIT_PFX);
  wire addr_hit = (addr7 == DEV_ADDR) && !addr_bad;
  wire in_idle = (state_r == TBCR_IDLE);
  wire in_data = (state_r == TBCR_DATA);
  wire wr_commit = byte_valid && in_data && !rw_r && !hw_shutdown;
  wire wr_vsel = wr_commit && (ptr_r == TBCR_ADDR_VSEL);
  wire wr_ch1 = wr_commit && (ptr_r == TBCR_ADDR_CH1);
  wire wr_ch2 = wr_commit && (ptr_r == TBCR_ADDR_CH2);
  wire wr_ch3 = wr_commit && (ptr_r == TBCR_ADDR_CH3);
  wire [7:0] rd_sel = (ptr_r == TBCR_ADDR_VSEL) ? vsel_r :
                      (ptr_r == TBCR_ADDR_CH1) ? ch1_r :
                      (ptr_r == TBCR_ADDR_CH2) ? ch2_r :
                      (ptr_r == TBCR_ADDR_CH3) ? ch3_r :
                      (ptr_r == TBCR_ADDR_STAT) ? stat_live : 8'h00;

  always_comb begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    if (bus_stop) begin
      state_nxt = TBCR_IDLE;
    end else if (bus_start) begin
      state_nxt = TBCR_IDLE;
    end else if (byte_valid) begin
      case (state_r)
        TBCR_IDLE: begin
          rw_nxt = byte_data[0];
          state_nxt = !addr_hit ? TBCR_SKIP : byte_data[0] ? TBCR_DATA : TBCR_REG;
        end
        TBCR_REG: begin
          ptr_nxt = byte_data;
          state_nxt = TBCR_DATA;
        end
        TBCR_DATA: begin
          ptr_nxt = ptr_r + 8'h01;
        end
        TBCR_SKIP: begin
          state_nxt = TBCR_SKIP;
        end
        default: begin
          state_nxt = TBCR_IDLE;
        end
      endcase
    end else if (rd_req && in_data && rw_r) begin
      ptr_nxt = ptr_r + 8'h01;
    end
  end

  // Own address is acked only in idle; every later byte of a hit is acked
  assign byte_ack = in_idle ? addr_hit : (state_r != TBCR_SKIP);
  assign rd_data = rd_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= TBCR_IDLE;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      rd_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      rd_r <= rd_sel;
    end
  end

  // Full bytes stored so unused bits read back as written
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vsel_r <= TBCR_RST_VSEL;
      ch1_r <= TBCR_RST_CMD;
      ch2_r <= TBCR_RST_CMD;
      ch3_r <= TBCR_RST_CMD;
    end else begin
      if (wr_vsel) vsel_r <= byte_data;
      if (wr_ch1) ch1_r <= byte_data;
      if (wr_ch2) ch2_r <= byte_data;
      if (wr_ch3) ch3_r <= byte_data;
    end
  end

  assign channel1_disable = ch1_r[TBCR_DISABLE_BIT];
  assign channel2_disable = ch2_r[TBCR_DISABLE_BIT];
  assign channel3_disable = ch3_r[TBCR_DISABLE_BIT];
  assign channel1_forced_continuous = ch1_r[TBCR_FCC_BIT];
  assign channel2_forced_continuous = ch2_r[TBCR_FCC_BIT];
  assign channel3_forced_continuous = ch3_r[TBCR_FCC_BIT];
  assign voltage_code_apply = vsel_r[TBCR_APPLY_BIT];

  // Code only moves while apply is set; with it clear the last code is held
  tbcr_slew u_slew (
    .core_clk(core_clk),
    .rst(rst),
    .sw_tick(sw_tick),
    .apply(vsel_r[TBCR_APPLY_BIT]),
    .target(vsel_r[6:0]),
    .slew_n(ch2_r[TBCR_SLEW_MSB:TBCR_SLEW_LSB]),
    .code_out(voltage_code),
    .step_pulse()
  );

  commit_late_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_ch1 |=> ch1_r == $past(byte_data))
    else $error("channel 1 write not stored");
  shutdown_block_a: assert property (@(posedge core_clk) disable iff (rst)
      hw_shutdown |=> $stable(vsel_r) && $stable(ch2_r))
    else $error("write accepted in hardware shutdown");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst)
      !is_mapped(ptr_r) |=> rd_r == 8'h00)
    else $error("unmapped read not zero");
  status_live_a: assert property (@(posedge core_clk) disable iff (rst)
      ptr_r == TBCR_ADDR_STAT |=> rd_r == $past(stat_live))
    else $error("status read not live");
  otp_bit_a: assert property (@(posedge core_clk) disable iff (rst)
      stat_live[TBCR_STAT_OTP] == mon_r[7])
    else $error("thermal shutdown bit wrong");
  gencall_nack_a: assert property (@(posedge core_clk) disable iff (rst)
      in_idle && byte_valid && addr7 == TBCR_GEN_CALL |-> !byte_ack)
    else $error("general call acknowledged");
  apply_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !voltage_code_apply ##1 !voltage_code_apply |-> $stable(voltage_code))
    else $error("code changed while not applied");
  disable_out_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_ch3 |=> channel3_disable == $past(byte_data[0]))
    else $error("channel 3 disable mismatch");
  write_cov: cover property (@(posedge core_clk) disable iff (rst) wr_vsel);
  read_stat_cov: cover property (@(posedge core_clk) disable iff (rst)
      rd_req && ptr_r == TBCR_ADDR_STAT);
  refuse_cov: cover property (@(posedge core_clk) disable iff (rst)
      byte_valid && in_data && hw_shutdown);
endmodule

/* bench/tbcr_host_model.sv */
/*
  Byte-level bus master model: conditions, byte sends and byte reads.
  Assumes a bit engine in front of the register bank, one byte per call.
*/
`timescale 1ns/10ps
module tbcr_host_model (
  input wire logic core_clk, // Clock
  output logic bus_start, // Start pulse
  output logic bus_stop, // Stop pulse
  output logic byte_valid, // Byte strobe
  output logic [7:0] byte_data, // Byte value
  output logic rd_req, // Read byte taken
  input wire logic byte_ack, // Acknowledge
  input wire logic [7:0] rd_data // Read byte
);
  initial begin
    {bus_start, bus_stop, byte_valid, rd_req} = 4'h0;
    byte_data = 8'hA5;
  end
  task automatic cond(input logic stop);
    @(posedge core_clk);
    if (stop) bus_stop <= 1'b1;
    else bus_start <= 1'b1;
    @(posedge core_clk);
    bus_start <= 1'b0;
    bus_stop <= 1'b0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    @(posedge core_clk);
    byte_valid <= 1'b1;
    byte_data <= b;
    #1 ack = byte_ack;
    @(posedge core_clk);
    byte_valid <= 1'b0;
    byte_data <= ~b; // Released lines must not keep the old byte
  endtask
  task automatic get(output logic [7:0] d);
    repeat (2) @(posedge core_clk);
    rd_req <= 1'b1;
    #1 d = rd_data;
    @(posedge core_clk);
    rd_req <= 1'b0;
  endtask
endmodule

/* bench/test_tbcr_regs.sv */
/*
  Self-checking bench for the register bank; each scenario is one task.
  Assumes the hand-over timing: combinational ack, one-cycle read lag.
*/
`timescale 1ns/10ps
module test_tbcr_regs;
  import tbcr_pkg::*;
  localparam logic [6:0] DEV = 7'h33; // Arbitrary bus address
  logic core_clk;
  logic rst;
  logic [2:0] en_pin;
  logic [7:0] mon;
  logic sw_tick;
  logic [1:0] tick_cnt = 2'h0;
  logic bus_start, bus_stop, byte_valid, rd_req, byte_ack;
  logic [7:0] byte_data, rd_data;
  logic [6:0] vcode;
  logic apply, dis1, dis2, dis3, fc1, fc2, fc3;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Ceiling far above the roughly 1300 cycles the scenarios need
  always @(posedge core_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    sw_tick <= (tick_cnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  tbcr_host_model i_host (.core_clk(core_clk), .bus_start(bus_start), .bus_stop(bus_stop),
    .byte_valid(byte_valid), .byte_data(byte_data), .rd_req(rd_req), .byte_ack(byte_ack),
    .rd_data(rd_data));
  tbcr_regs #(.DEV_ADDR(DEV)) i_dut (.core_clk(core_clk), .rst(rst), .bus_start(bus_start),
    .bus_stop(bus_stop), .byte_valid(byte_valid), .byte_data(byte_data), .rd_req(rd_req),
    .byte_ack(byte_ack), .rd_data(rd_data), .en_pin(en_pin), .over_temp_in(mon[7]),
    .temp_warn_in(mon[3]), .overcurrent_in(mon[6:4]), .in_regulation_in(mon[2:0]),
    .sw_tick(sw_tick), .voltage_code(vcode), .voltage_code_apply(apply),
    .channel1_disable(dis1), .channel2_disable(dis2), .channel3_disable(dis3),
    .channel1_forced_continuous(fc1), .channel2_forced_continuous(fc2),
    .channel3_forced_continuous(fc3));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] k;
    i_host.cond(1'b0);
    i_host.put({DEV, 1'b0}, k[0]);
    i_host.put(a, k[1]);
    i_host.put(d, k[2]);
    i_host.cond(1'b1);
    chk({5'h0, k}, 8'h07);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic k;
    logic [7:0] d;
    i_host.cond(1'b0);
    i_host.put({DEV, 1'b0}, k);
    i_host.put(a, k);
    i_host.cond(1'b0);
    i_host.put({DEV, 1'b1}, k);
    i_host.get(d);
    i_host.cond(1'b1);
    chk(d, exp);
  endtask
  task automatic t_reset();
    rdchk(TBCR_ADDR_VSEL, 8'h00);
    for (int c = 3; c < 7; c++) rdchk(8'(c), 8'h00);
    chk({fc3, fc2, fc1, dis3, dis2, dis1, apply, vcode[0]}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_rw();
    logic [7:0] v [2] = '{8'hFF, 8'h56};
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 3; c++) wr(TBCR_ADDR_CH1 + 8'(c), v[p] ^ 8'(c << 2));
      chk({fc3, fc2, fc1, dis3, dis2, dis1}, {{3{v[p][1]}}, {3{v[p][0]}}});
      for (int c = 0; c < 3; c++) rdchk(TBCR_ADDR_CH1 + 8'(c), v[p] ^ 8'(c << 2));
    end
    $display("test rw done");
  endtask
  task automatic t_status();
    logic [7:0] pat [3] = '{8'hA5, 8'h5A, 8'h00};
    foreach (pat[i]) begin
      mon <= pat[i];
      repeat (6) @(posedge core_clk);
      rdchk(TBCR_ADDR_STAT, pat[i]);
    end
    wr(TBCR_ADDR_STAT, 8'hFF);
    rdchk(TBCR_ADDR_STAT, 8'h00);
    $display("test status done");
  endtask
  task automatic t_undec();
    logic [7:0] a [4] = '{8'h00, 8'h02, 8'h07, 8'hFF};
    foreach (a[i]) wr(a[i], 8'hFF);
    foreach (a[i]) rdchk(a[i], 8'h00);
    rdchk(TBCR_ADDR_CH1, 8'h56);
    $display("test undecoded done");
  endtask
  task automatic t_addr();
    logic [7:0] b [3] = '{{DEV ^ 7'h01, 1'b0}, 8'h00, 8'hF0};
    logic k;
    foreach (b[i]) begin
      i_host.cond(1'b0);
      i_host.put(b[i], k);
      chk({7'h0, k}, 8'h00);
      i_host.put(TBCR_ADDR_CH1, k);
      i_host.put(8'hFF, k);
      i_host.cond(1'b1);
    end
    rdchk(TBCR_ADDR_CH1, 8'h56);
    $display("test address done");
  endtask
  task automatic t_shut();
    en_pin <= 3'h0;
    repeat (6) @(posedge core_clk);
    wr(TBCR_ADDR_CH1, 8'hFF);
    en_pin <= 3'h7;
    repeat (6) @(posedge core_clk);
    rdchk(TBCR_ADDR_CH1, 8'h56);
    $display("test shutdown done");
  endtask
  task automatic t_slew();
    wr(TBCR_ADDR_CH2, 8'h00);
    wr(TBCR_ADDR_VSEL, 8'h05);
    repeat (30) @(posedge core_clk);
    chk({apply, vcode}, 8'h00);
    wr(TBCR_ADDR_VSEL, 8'h85);
    repeat (30) @(posedge core_clk);
    chk({apply, vcode}, 8'h85);
    wr(TBCR_ADDR_CH2, 8'h20);
    wr(TBCR_ADDR_VSEL, 8'h87);
    repeat (12) @(posedge core_clk);
    chk({7'h0, vcode == 7'h07}, 8'h00);
    repeat (60) @(posedge core_clk);
    chk({apply, vcode}, 8'h87);
    wr(TBCR_ADDR_CH2, 8'h00);
    wr(TBCR_ADDR_VSEL, 8'hFF);
    repeat (520) @(posedge core_clk);
    chk({apply, vcode}, 8'hFF);
    $display("test slew done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst <= 1'b1;
    en_pin <= 3'h7;
    mon <= 8'h00;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    t_reset();
    t_rw();
    t_status();
    t_undec();
    t_addr();
    t_shut();
    t_slew();
    stop_test();
  end
endmodule
